// [logic/hptc_top.sv]
// What this block does
// - The overdrive amplitude is 8 bits of 0.78 percent steps whose top sign bit software keeps at zero.
// - The overdrive period lasts the overdrive count times 5 ms.
// - The normal drive amplitude is 8 bits of 0.78 percent steps whose top sign bit software keeps at zero.
// - The normal drive period lasts the drive count times 10 ms.
// - The brake amplitude is 8 bits of 0.78 percent steps whose sign bit software sets to one for reverse drive.
// - The braking period lasts the brake count times 5 ms.
// - With auto brake enabled braking stops when the actuator stops, the brake count being only the limit.
// - The pattern address register picks the memory entry the data byte registers reach.
// - The high data byte holds behaviour code in 7:6, sign in 5 and amplitude bits 6:2 in 4:0.
// - Code 00 ends, 01 continues, 10 drives the mean of its own and the next sample's amplitude, 11 replays the whole pattern.
// - A sample sign of zero drives positive and one drives negative.
// - The middle data byte holds amplitude bits 1:0 in 7:6, duration in 5:1 and wait bit 4 in 0.
// - A sample drives for duration times 5 ms, then rests at zero for wait times 5 ms.
// - The 4-bit repeat count replays a sample, or under code 11 the whole pattern, 0 to 15 times.
`include "hptc_map.svh"

module hptc_top #(
   parameter int STEP_CYC = `HPTC_STEP_CYC,
   parameter int MEM_DEPTH = 256
) (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rstn,
   // register port
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   // control
   input  wire logic       ext_trigger,
   input  wire logic       pattern_go,
   input  wire logic       auto_brake_disable,
   input  wire logic       actuator_stopped,
   // actuator drive
   output logic      [6:0] drive_amp,
   output logic            drive_negative,
   output logic            brake_active,
   output logic            seq_busy
);
   import hptc_pkg::*;

   if (MEM_DEPTH != 256) begin : g_chk
      $error("hptc_top: MEM_DEPTH must be 256 for an 8-bit pattern address");
   end

   typedef struct packed {
      hptc_state_t st;
      logic [7:0]  overdrive_amplitude;
      logic [7:0]  overdrive_duration;
      logic [7:0]  drive_amplitude;
      logic [7:0]  drive_duration;
      logic [7:0]  brake_amplitude;
      logic [7:0]  brake_duration;
      logic [7:0]  pattern_address;
      logic [7:0]  rdata;
      logic [7:0]  idx;
      logic [3:0]  srep;
      logic [3:0]  prep;
      logic        tmr_start;
      logic        tmr_abort;
      hptc_units_t tmr_units;
      logic [6:0]  amp;
      logic        neg;
      logic        brake;
      logic        busy;
   } hptc_st_t;

   hptc_st_t     q, d;
   hptc_sample_t pattern_mem [MEM_DEPTH];

   hptc_tmr_if tmr_bus ();

   hptc_timer #(.STEP_CYC(STEP_CYC)) u_timer (
      .clk  (clk),
      .rstn (rstn),
      .tm   (tmr_bus.tmr)
   );

   // ======================================
   // sample field decoding
   function automatic logic [6:0] samp_amp(input hptc_sample_t s);
      return {s[`HPTC_F_AMPH_HI:`HPTC_F_AMPH_LO], s[`HPTC_F_AMPL_HI:`HPTC_F_AMPL_LO]};
   endfunction : samp_amp

   function automatic hptc_units_t samp_dur(input hptc_sample_t s);
      return {4'h0, s[`HPTC_F_DUR_HI:`HPTC_F_DUR_LO]};
   endfunction : samp_dur

   function automatic hptc_units_t samp_wait(input hptc_sample_t s);
      return {4'h0, s[`HPTC_F_WAIT4], s[`HPTC_F_WAITL_HI:`HPTC_F_WAITL_LO]};
   endfunction : samp_wait

   function automatic hptc_code_t samp_code(input hptc_sample_t s);
      return hptc_code_t'(s[`HPTC_F_CODE_HI:`HPTC_F_CODE_LO]);
   endfunction : samp_code

   hptc_sample_t cur_s;
   hptc_sample_t nxt_s;
   assign cur_s = pattern_mem[q.pattern_address];

   // ======================================
   // pattern memory
   always_ff @(posedge clk) begin
      if (reg_wr) begin
         case (reg_addr)
            `HPTC_OFF_PAT_HIGH: pattern_mem[q.pattern_address][23:16] <= reg_wdata;
            `HPTC_OFF_PAT_MID:  pattern_mem[q.pattern_address][15:8] <= reg_wdata;
            `HPTC_OFF_PAT_LOW:  pattern_mem[q.pattern_address][7:0] <= reg_wdata;
            default: ;
         endcase
      end
   end

   // ======================================
   // registers and sequencer
   always_comb begin
      hptc_sample_t s;
      logic [7:0]   nidx;
      logic [7:0]   iamp;
      s     = pattern_mem[q.idx];
      nidx  = 8'(q.idx + 8'h01);
      iamp  = 8'h00;
      nxt_s = pattern_mem[nidx];
      d     = q;
      d.tmr_start = 1'b0;
      d.tmr_abort = 1'b0;

      if (reg_wr) begin
         case (reg_addr)
            `HPTC_OFF_OD_AMP:   d.overdrive_amplitude = reg_wdata;
            `HPTC_OFF_OD_DUR:   d.overdrive_duration  = reg_wdata;
            `HPTC_OFF_ACT_AMP:  d.drive_amplitude     = reg_wdata;
            `HPTC_OFF_ACT_DUR:  d.drive_duration      = reg_wdata;
            `HPTC_OFF_BRK_AMP:  d.brake_amplitude     = reg_wdata;
            `HPTC_OFF_BRK_DUR:  d.brake_duration      = reg_wdata;
            `HPTC_OFF_PAT_ADDR: d.pattern_address     = reg_wdata;
            default: ;
         endcase
      end

      if (reg_rd) begin
         case (reg_addr)
            `HPTC_OFF_OD_AMP:   d.rdata = q.overdrive_amplitude;
            `HPTC_OFF_OD_DUR:   d.rdata = q.overdrive_duration;
            `HPTC_OFF_ACT_AMP:  d.rdata = q.drive_amplitude;
            `HPTC_OFF_ACT_DUR:  d.rdata = q.drive_duration;
            `HPTC_OFF_BRK_AMP:  d.rdata = q.brake_amplitude;
            `HPTC_OFF_BRK_DUR:  d.rdata = q.brake_duration;
            `HPTC_OFF_PAT_ADDR: d.rdata = q.pattern_address;
            `HPTC_OFF_PAT_HIGH: d.rdata = cur_s[23:16];
            `HPTC_OFF_PAT_MID:  d.rdata = cur_s[15:8];
            `HPTC_OFF_PAT_LOW:  d.rdata = cur_s[7:0];
            default:            d.rdata = 8'h00;
         endcase
      end

      case (q.st)
         HPTC_IDLE: begin
            if (ext_trigger) begin
               d.st        = HPTC_OVERDRIVE;
               d.tmr_start = 1'b1;
               d.tmr_units = {1'b0, q.overdrive_duration};
            end else if (pattern_go) begin
               d.st        = HPTC_PAT_OUT;
               d.idx       = 8'h00;
               d.srep      = 4'h0;
               d.prep      = 4'h0;
               d.tmr_start = 1'b1;
               d.tmr_units = samp_dur(pattern_mem[8'h00]);
            end
         end
         HPTC_OVERDRIVE: begin
            if (tmr_bus.done) begin
               d.st        = HPTC_DRIVE;
               d.tmr_start = 1'b1;
               d.tmr_units = {q.drive_duration, 1'b0};
            end
         end
         HPTC_DRIVE: begin
            if (tmr_bus.done) begin
               d.st        = HPTC_BRAKE;
               d.tmr_start = 1'b1;
               d.tmr_units = {1'b0, q.brake_duration};
            end
         end
         HPTC_BRAKE: begin
            if (!auto_brake_disable && actuator_stopped) begin
               d.st        = HPTC_IDLE;
               d.tmr_abort = 1'b1;
            end else if (tmr_bus.done) begin
               d.st        = HPTC_IDLE;
            end
         end
         HPTC_PAT_OUT: begin
            if (tmr_bus.done) begin
               d.st        = HPTC_PAT_WAIT;
               d.tmr_start = 1'b1;
               d.tmr_units = samp_wait(s);
            end
         end
         HPTC_PAT_WAIT: begin
            if (tmr_bus.done) begin
               d.st        = HPTC_PAT_OUT;
               d.tmr_start = 1'b1;
               d.tmr_units = samp_dur(s);
               if (samp_code(s) != HPTC_CODE_REPLAY && q.srep < s[`HPTC_F_RPT_HI:`HPTC_F_RPT_LO]) begin
                  d.srep = q.srep + 4'h1;
               end else begin
                  d.srep = 4'h0;
                  case (samp_code(s))
                     HPTC_CODE_NEXT, HPTC_CODE_INTERP: begin
                        d.idx       = nidx;
                        d.tmr_units = samp_dur(nxt_s);
                     end
                     HPTC_CODE_REPLAY: begin
                        if (q.prep < s[`HPTC_F_RPT_HI:`HPTC_F_RPT_LO]) begin
                           d.prep      = q.prep + 4'h1;
                           d.idx       = 8'h00;
                           d.tmr_units = samp_dur(pattern_mem[8'h00]);
                        end else begin
                           d.st        = HPTC_IDLE;
                           d.tmr_start = 1'b0;
                        end
                     end
                     default: begin
                        d.st        = HPTC_IDLE;
                        d.tmr_start = 1'b0;
                     end
                  endcase
               end
            end
         end
         default: d.st = HPTC_IDLE;
      endcase

      // output follows the next state so it changes with the state
      d.amp   = 7'h00;
      d.neg   = 1'b0;
      d.brake = 1'b0;
      case (d.st)
         HPTC_OVERDRIVE: begin
            d.amp = d.overdrive_amplitude[6:0];
            d.neg = d.overdrive_amplitude[`HPTC_F_SIGN8];
         end
         HPTC_DRIVE: begin
            d.amp = d.drive_amplitude[6:0];
            d.neg = d.drive_amplitude[`HPTC_F_SIGN8];
         end
         HPTC_BRAKE: begin
            d.amp   = d.brake_amplitude[6:0];
            d.neg   = d.brake_amplitude[`HPTC_F_SIGN8];
            d.brake = 1'b1;
         end
         HPTC_PAT_OUT: begin
            iamp  = {1'b0, samp_amp(pattern_mem[d.idx])};
            d.amp = iamp[6:0];
            if (samp_code(pattern_mem[d.idx]) == HPTC_CODE_INTERP) begin
               iamp  = 8'((iamp + {1'b0, samp_amp(pattern_mem[8'(d.idx + 8'h01)])}) >> 1);
               d.amp = iamp[6:0];
            end
            d.neg = pattern_mem[d.idx][`HPTC_F_SIGN];
         end
         default: ;
      endcase
      d.busy = (d.st != HPTC_IDLE);
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         q                     <= '0;
         q.st                  <= HPTC_IDLE;
         q.overdrive_amplitude <= `HPTC_RST_REG;
         q.overdrive_duration  <= `HPTC_RST_REG;
         q.drive_amplitude     <= `HPTC_RST_REG;
         q.drive_duration      <= `HPTC_RST_REG;
         q.brake_amplitude     <= `HPTC_RST_REG;
         q.brake_duration      <= `HPTC_RST_REG;
         q.pattern_address     <= `HPTC_RST_REG;
      end else begin
         q <= d;
      end
   end

   assign tmr_bus.start  = q.tmr_start;
   assign tmr_bus.abort  = q.tmr_abort;
   assign tmr_bus.units  = q.tmr_units;
   assign reg_rdata      = q.rdata;
   assign drive_amp      = q.amp;
   assign drive_negative = q.neg;
   assign brake_active   = q.brake;
   assign seq_busy       = q.busy;

   // ======================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   od_output_a: assert property (q.st == HPTC_OVERDRIVE |-> drive_amp == q.overdrive_amplitude[6:0]
      && drive_negative == q.overdrive_amplitude[7]) else $error("overdrive amplitude wrong");
   drv_output_a: assert property (q.st == HPTC_DRIVE |-> drive_amp == q.drive_amplitude[6:0] && !brake_active)
      else $error("drive amplitude wrong");
   brk_output_a: assert property (q.st == HPTC_BRAKE |-> brake_active
      && drive_negative == q.brake_amplitude[7]) else $error("brake output wrong");
   drv_units_a: assert property ($rose(q.st == HPTC_DRIVE) |-> tmr_bus.start
      && tmr_bus.units == {$past(q.drive_duration), 1'b0}) else $error("drive time not doubled");
   brk_units_a: assert property ($rose(q.st == HPTC_BRAKE)
      |=> tmr_bus.units == {1'b0, $past(q.brake_duration)}) else $error("brake time wrong");
   seq_order_a: assert property (q.st == HPTC_OVERDRIVE ##1 q.st != HPTC_OVERDRIVE |-> q.st == HPTC_DRIVE)
      else $error("overdrive not followed by drive");
   brk_order_a: assert property (q.st == HPTC_DRIVE ##1 q.st != HPTC_DRIVE |-> q.st == HPTC_BRAKE)
      else $error("drive not followed by brake");
   tmr_idle_a: assert property (q.st == HPTC_IDLE && $past(q.st) == HPTC_IDLE |-> !tmr_bus.busy)
      else $error("timer left running in idle");
   auto_brake_a: assert property (q.st == HPTC_BRAKE && !auto_brake_disable && actuator_stopped
      |=> q.st == HPTC_IDLE && !brake_active && drive_amp == 7'h00) else $error("auto brake ignored");
   fixed_brake_a: assert property (q.st == HPTC_BRAKE && auto_brake_disable && !tmr_bus.done
      |=> q.st == HPTC_BRAKE) else $error("fixed brake cut short");
   pat_read_a: assert property (reg_rd && reg_addr == `HPTC_OFF_PAT_HIGH
      |=> reg_rdata == $past(cur_s[23:16])) else $error("pattern high byte read wrong");
   pat_sign_a: assert property (q.st == HPTC_PAT_OUT |-> drive_negative == pattern_mem[q.idx][21])
      else $error("sample sign wrong");
   pat_wait_a: assert property (q.st == HPTC_PAT_WAIT |-> drive_amp == 7'h00 && !drive_negative)
      else $error("wait not at zero");
   pat_last_a: assert property (q.st == HPTC_PAT_WAIT && tmr_bus.done
      && samp_code(pattern_mem[q.idx]) == HPTC_CODE_LAST
      && q.srep >= pattern_mem[q.idx][3:0] |=> q.st == HPTC_IDLE) else $error("last sample did not end");

endmodule : hptc_top

// [logic/hptc_map.svh]
`ifndef HPTC_MAP_SVH
`define HPTC_MAP_SVH

// ======================================
// register offsets
`define HPTC_OFF_OD_AMP   8'h30
`define HPTC_OFF_OD_DUR   8'h31
`define HPTC_OFF_ACT_AMP  8'h32
`define HPTC_OFF_ACT_DUR  8'h33
`define HPTC_OFF_BRK_AMP  8'h34
`define HPTC_OFF_BRK_DUR  8'h35
`define HPTC_OFF_PAT_ADDR 8'h40
`define HPTC_OFF_PAT_HIGH 8'h41
`define HPTC_OFF_PAT_MID  8'h42
`define HPTC_OFF_PAT_LOW  8'h43

// ======================================
// reset values
`define HPTC_RST_REG 8'h00

// ======================================
// field positions in a 24-bit sample {high, mid, low}
`define HPTC_F_CODE_HI  23
`define HPTC_F_CODE_LO  22
`define HPTC_F_SIGN     21
`define HPTC_F_AMPH_HI  20
`define HPTC_F_AMPH_LO  16
`define HPTC_F_AMPL_HI  15
`define HPTC_F_AMPL_LO  14
`define HPTC_F_DUR_HI   13
`define HPTC_F_DUR_LO   9
`define HPTC_F_WAIT4    8
`define HPTC_F_WAITL_HI 7
`define HPTC_F_WAITL_LO 4
`define HPTC_F_RPT_HI   3
`define HPTC_F_RPT_LO   0
`define HPTC_F_SIGN8    7

// ======================================
// timing
`define HPTC_STEP_MS      5
`define HPTC_CLK_PERIOD_NS 10
`define HPTC_STEP_CYC     ((`HPTC_STEP_MS * 1000000) / `HPTC_CLK_PERIOD_NS)

`endif

// [logic/hptc_pkg.sv]
package hptc_pkg;

   // ======================================
   // sequencer states
   typedef enum logic [2:0] {
      HPTC_IDLE,
      HPTC_OVERDRIVE,
      HPTC_DRIVE,
      HPTC_BRAKE,
      HPTC_PAT_OUT,
      HPTC_PAT_WAIT
   } hptc_state_t;

   // ======================================
   // sample behaviour codes
   typedef enum logic [1:0] {
      HPTC_CODE_LAST   = 2'h0,
      HPTC_CODE_NEXT   = 2'h1,
      HPTC_CODE_INTERP = 2'h2,
      HPTC_CODE_REPLAY = 2'h3
   } hptc_code_t;

   typedef logic [23:0] hptc_sample_t;
   typedef logic [8:0]  hptc_units_t;

endpackage : hptc_pkg

// [logic/hptc_tmr_if.sv]
interface hptc_tmr_if;
   import hptc_pkg::*;
   logic        start;
   logic        abort;
   hptc_units_t units;
   logic        done;
   logic        busy;

   modport ctl (output start, output abort, output units, input done, input busy);
   modport tmr (input start, input abort, input units, output done, output busy);
endinterface : hptc_tmr_if

// [logic/hptc_timer.sv]
`include "hptc_map.svh"

module hptc_timer #(
   parameter int STEP_CYC = `HPTC_STEP_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // control
   hptc_tmr_if.tmr  tm
);
   import hptc_pkg::*;

   localparam int CW = $clog2(STEP_CYC);

   if (STEP_CYC < 2) begin : g_chk
      $error("hptc_timer: STEP_CYC must be at least 2");
   end

   typedef struct packed {
      logic          busy;
      logic          done;
      logic [CW-1:0] step;
      hptc_units_t   left;
   } hptc_tmr_st_t;

   hptc_tmr_st_t q, d;

   // ======================================
   // step counter
   always_comb begin
      d = q;
      d.done = 1'b0;
      if (tm.start) begin
         d.busy = 1'b1;
         d.step = '0;
         d.left = tm.units;
      end else if (tm.abort) begin
         d.busy = 1'b0;
      end else if (q.busy) begin
         if (q.left == '0) begin
            d.busy = 1'b0;
            d.done = 1'b1;
         end else if (q.step == CW'(STEP_CYC - 1)) begin
            d.step = '0;
            d.left = q.left - 9'h001;
         end else begin
            d.step = q.step + CW'(1);
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign tm.done = q.done;
   assign tm.busy = q.busy;

   // ======================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   step_unit_a: assert property (q.busy && !tm.start && !tm.abort && q.left != '0
      && q.step == CW'(STEP_CYC - 1) |=> q.left == $past(q.left) - 9'h001)
      else $error("unit not consumed at step end");
   zero_units_a: assert property (tm.start && tm.units == '0 ##1 !tm.start && !tm.abort |=> q.done)
      else $error("zero duration not finished in two cycles");

endmodule : hptc_timer

// [tb/hptc_actuator_model.sv]
// ======================================
// actuator model: stops a set time into braking
module hptc_actuator_model (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // drive from the block
   input  wire logic [6:0]  drive_amp,
   input  wire logic        brake_active,
   // model setting
   input  wire logic [15:0] stop_delay,
   // motion state
   output logic             actuator_stopped
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] brake_cyc_q;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         brake_cyc_q <= 16'h0000;
      end else if (brake_active && brake_cyc_q != 16'hffff) begin
         brake_cyc_q <= brake_cyc_q + 16'h0001;
      end else if (!brake_active) begin
         brake_cyc_q <= 16'h0000;
      end
   end

   // motion ends once braked long enough
   assign actuator_stopped = brake_active ? (brake_cyc_q >= stop_delay) : (drive_amp == 7'h00);
endmodule : hptc_actuator_model

// [tb/test_haptic_trigger_pattern_ctrl.sv]
`include "hptc_map.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; \
   $display("ERROR %s expected %0h seen %0h", nm, e, g); end end

module test_haptic_trigger_pattern_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int S = 4;
   localparam int BIG = 100000;
   typedef struct {logic rd; logic [8:0] tup; logic [7:0] val; int lo; int hi;} hptc_note_t;
   logic        clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0;
   logic        ext_trigger = 0, pattern_go = 0, auto_brake_disable = 0;
   logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic [15:0] stop_delay = 16'h0003;
   logic [6:0]  drive_amp;
   logic        drive_negative, brake_active, seq_busy, actuator_stopped, rd_seen;
   logic [8:0]  prev_tup, now_tup;
   int          miscompares = 0, check_count = 0, el;
   hptc_note_t  q[$];
   hptc_note_t  cur;

   always #5 clk = ~clk;

   hptc_top #(.STEP_CYC(S)) uut (.clk(clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .ext_trigger(ext_trigger),
      .pattern_go(pattern_go), .auto_brake_disable(auto_brake_disable), .actuator_stopped(actuator_stopped),
      .drive_amp(drive_amp), .drive_negative(drive_negative), .brake_active(brake_active), .seq_busy(seq_busy));

   hptc_actuator_model partner (.clk(clk), .rstn(rstn), .drive_amp(drive_amp), .brake_active(brake_active),
      .stop_delay(stop_delay), .actuator_stopped(actuator_stopped));

   function automatic hptc_note_t take();
      hptc_note_t n;
      n = '{1'b0, 9'hxxx, 8'hxx, 0, BIG};
      if (q.size() > 0) n = q.pop_front();
      return n;
   endfunction : take

   // ======================================
   // monitor: oldest note against each result
   always @(posedge clk) begin
      hptc_note_t n;
      now_tup = {brake_active, drive_negative & (drive_amp != 7'h00), drive_amp};
      if (!rstn) begin
         prev_tup = 9'h000;
         el = 0;
         cur = '{1'b0, 9'h000, 8'h00, 0, BIG};
         rd_seen = 1'b0;
      end else begin
         if (rd_seen) begin
            n = take();
            `CHK("reg_rdata", n.val, reg_rdata)
         end
         rd_seen = reg_rd;
         el++;
         if (now_tup !== prev_tup) begin
            `CHK("segment length ok", 1'b1, (el >= cur.lo && el <= cur.hi))
            cur = take();
            `CHK("drive output", cur.tup, now_tup)
            prev_tup = now_tup;
            el = 0;
         end
      end
   end

   // ======================================
   // bus and sequence tasks
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      q.push_back('{1'b1, 9'h000, e, 0, 0});
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
   endtask : rd

   task automatic seg(input logic [8:0] t, input int u);
      q.push_back('{1'b0, t, 8'h00, u * S, u * S + 6});
   endtask : seg

   task automatic fin();
      q.push_back('{1'b0, 9'h000, 8'h00, 0, BIG});
   endtask : fin

   task automatic ent(input logic [7:0] i, input logic [1:0] c, input logic s, input logic [6:0] a,
                      input logic [4:0] d, input logic [4:0] w, input logic [3:0] r);
      wr(`HPTC_OFF_PAT_ADDR, i);
      wr(`HPTC_OFF_PAT_HIGH, {c, s, a[6:2]});
      wr(`HPTC_OFF_PAT_MID, {a[1:0], d, w[4]});
      wr(`HPTC_OFF_PAT_LOW, {w[3:0], r});
      rd(`HPTC_OFF_PAT_HIGH, {c, s, a[6:2]});
      rd(`HPTC_OFF_PAT_MID, {a[1:0], d, w[4]});
      rd(`HPTC_OFF_PAT_LOW, {w[3:0], r});
   endtask : ent

   task automatic run(input logic trig);
      @(posedge clk);
      if (trig) ext_trigger <= 1'b1;
      else pattern_go <= 1'b1;
      @(posedge clk);
      ext_trigger <= 1'b0;
      pattern_go <= 1'b0;
      @(negedge clk);
      `CHK("seq_busy", 1'b1, seq_busy)
      @(posedge clk);
      ext_trigger <= 1'b1;
      pattern_go <= 1'b1;
      @(posedge clk);
      ext_trigger <= 1'b0;
      pattern_go <= 1'b0;
      for (int i = 0; i < 5000 && seq_busy !== 1'b0; i++) @(negedge clk);
      `CHK("seq_busy", 1'b0, seq_busy)
      repeat (4) @(posedge clk);
   endtask : run

   task automatic end_sim();
      `CHK("notes left", 0, q.size())
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : end_sim

   initial begin
      repeat (60000) @(posedge clk);
      miscompares++;
      end_sim();
   end

   // ======================================
   // tests
   initial begin
      logic [7:0] tv [6];
      int am [3];
      int du [3];
      int wt [3];
      logic sg [3];
      void'($urandom(32'h0000_8615));
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      for (int i = 0; i < 6; i++) rd(8'h30 + 8'(i), 8'h00);
      rd(`HPTC_OFF_PAT_ADDR, 8'h00);
      wr(8'h36, 8'h5a);
      rd(8'h36, 8'h00);
      wr(`HPTC_OFF_PAT_ADDR, 8'h07);
      wr(`HPTC_OFF_PAT_HIGH, 8'h6b);
      wr(`HPTC_OFF_PAT_ADDR, 8'h09);
      wr(`HPTC_OFF_PAT_HIGH, 8'h94);
      wr(`HPTC_OFF_PAT_ADDR, 8'h07);
      rd(`HPTC_OFF_PAT_HIGH, 8'h6b);
      rd(`HPTC_OFF_PAT_ADDR, 8'h07);
      $display("test registers done");
      for (int t = 0; t < 3; t++) begin
         tv[0] = 8'($urandom_range(64, 127));
         tv[1] = (t == 2) ? 8'h00 : 8'($urandom_range(1, 6));
         tv[2] = 8'($urandom_range(1, 63));
         tv[3] = 8'($urandom_range(1, 4));
         tv[4] = 8'h80 | 8'($urandom_range(1, 127));
         tv[5] = 8'h14;
         auto_brake_disable <= (t == 0);
         stop_delay <= (t == 2) ? 16'h01f4 : 16'h0003;
         for (int i = 0; i < 6; i++) wr(8'h30 + 8'(i), tv[i]);
         for (int i = 0; i < 6; i++) rd(8'h30 + 8'(i), tv[i]);
         seg({1'b0, tv[0]}, tv[1]);
         seg({1'b0, tv[2]}, 2 * tv[3]);
         if (t == 1) q.push_back('{1'b0, {1'b1, tv[4]}, 8'h00, 2, 8});
         else seg({1'b1, tv[4]}, tv[5]);
         fin();
         run(1'b1);
         $display("test trigger %0d done", t);
      end
      for (int i = 0; i < 3; i++) begin
         am[i] = 2 * $urandom_range(1, 63);
         du[i] = $urandom_range(1, 3);
         wt[i] = $urandom_range(1, 17);
         sg[i] = 1'($urandom_range(0, 1));
      end
      sg[1] = sg[0];
      ent(8'h00, 2'b10, sg[0], 7'(am[0]), 5'(du[0]), 5'(wt[0]), 4'h0);
      ent(8'h01, 2'b01, sg[1], 7'(am[1]), 5'(du[1]), 5'(wt[1]), 4'h1);
      ent(8'h02, 2'b11, sg[2], 7'(am[2] - 1), 5'(du[2]), 5'(wt[2]), 4'h1);
      for (int r = 0; r < 2; r++) begin
         seg({1'b0, sg[0], 7'((am[0] + am[1]) / 2)}, du[0]);
         seg(9'h000, wt[0]);
         for (int k = 0; k < 2; k++) begin
            seg({1'b0, sg[1], 7'(am[1])}, du[1]);
            seg(9'h000, wt[1]);
         end
         seg({1'b0, sg[2], 7'(am[2] - 1)}, du[2]);
         if (r == 1) fin();
         else seg(9'h000, wt[2]);
      end
      run(1'b0);
      $display("test pattern replay done");
      ent(8'h00, 2'b00, ~sg[2], 7'(am[2]), 5'(du[2]), 5'(wt[2]), 4'h2);
      for (int k = 0; k < 3; k++) begin
         seg({1'b0, ~sg[2], 7'(am[2])}, du[2]);
         if (k == 2) fin();
         else seg(9'h000, wt[2]);
      end
      run(1'b0);
      $display("test pattern last done");
      end_sim();
   end
endmodule : test_haptic_trigger_pattern_ctrl
